// ==== verilog/adc_serial_pkg.sv ====
package adc_serial_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ           = 250000000;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned OSC_HZ           = 1800000;                        // on-chip oscillator, nominal
  localparam int unsigned OSC_DIV_CYC      = CLK_HZ / OSC_HZ;                // core cycles per modulator sample
  localparam int unsigned EXT_CLK_DIV      = 5;                              // external clock edges per sample
  localparam int unsigned EXT_IDLE_CYC     = 4096;                           // no edge this long: pin is grounded
  localparam int unsigned SLEEP_NS         = 500;                            // least time asleep
  localparam int unsigned SLEEP_CYC        = (SLEEP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SCK_HALF_NS      = 100;                            // serial clock half period
  localparam int unsigned SCK_HALF_CYC     = (SCK_HALF_NS * CLK_MHZ) / 1000;

  // oversample ratio: 64 << index, index 0..9
  localparam int unsigned RATIO_BASE_LOG2  = 6;
  localparam int unsigned RATIO_MAX_IDX    = 9;
  localparam int unsigned CONV_PER_NOTCH_LOG2 = 3;                           // output rate is notch / 8
  localparam int unsigned CONV_CNT_W       = 19;

  // serial word
  localparam int unsigned WORD_BITS        = 32;
  localparam int unsigned SDI_CODE_BITS    = 5;
  localparam logic [4:0]  SDI_CODE_SLOWEST = 5'h1F;                          // input tied high
  localparam logic [5:0]  ABORT_MIN_EDGES  = 6'h05;

  // register map
  localparam logic [7:0]  CTRL_OFFSET      = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET    = 8'h04;
  localparam logic [7:0]  RESULT_OFFSET    = 8'h08;
  localparam logic [7:0]  COUNT_OFFSET     = 8'h0C;
  localparam int unsigned CTRL_RATIO_LSB   = 0;
  localparam int unsigned CTRL_SDI_SEL_BIT = 4;
  localparam logic [3:0]  CTRL_RATIO_RESET = 4'h0;                          // fastest ratio keeps the first conversion short
  localparam logic        CTRL_SDI_RESET   = 1'b1;
  localparam int unsigned STAT_BUSY_BIT    = 0;
  localparam int unsigned STAT_EXT_BIT     = 1;
  localparam int unsigned STAT_STATE_LSB   = 2;
  localparam int unsigned STAT_IDX_LSB     = 4;
  localparam int unsigned STAT_EDGES_LSB   = 8;

  typedef enum logic [1:0] {CONVERT, SLEEP, SHIFT} convState_t;

  typedef struct packed {
    logic [31:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } apbReq_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apbRsp_t;

  typedef struct packed {
    logic sck;
    logic sckOe;
    logic sdo;
    logic sdoOe;
    logic busy;
  } serialPins_t;

endpackage

// ==== verilog/sample_rate_gen.sv ====
`timescale 1ns/1ps
module sample_rate_gen (
  input  wire logic core_clk,
  input  wire logic srst,
  input  wire logic conversionClockPin,
  output logic      sampleTick,
  output logic      extActive
);
  import adc_serial_pkg::*;

  logic       pinMeta_q;
  logic       pinSync_q;
  logic       pinLast_q;
  logic [7:0] oscCnt_q;
  logic [2:0] extCnt_q;
  logic [12:0] idleCnt_q;
  logic       pinRise;

  // two-flop synchroniser, then edge history
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinMeta_q <= 1'b0;
      pinSync_q <= 1'b0;
      pinLast_q <= 1'b0;
    end else begin
      pinMeta_q <= conversionClockPin;
      pinSync_q <= pinMeta_q;
      pinLast_q <= pinSync_q;
    end
  end

  assign pinRise = pinSync_q & ~pinLast_q;

  // a pin that stops toggling counts as grounded
  always_ff @(posedge core_clk) begin
    if (srst) begin
      idleCnt_q <= 13'h0000;
      extActive <= 1'b0;
    end else if (pinRise) begin
      idleCnt_q <= 13'h0000;
      extActive <= 1'b1;
    end else if (idleCnt_q == 13'(EXT_IDLE_CYC - 1)) begin
      extActive <= 1'b0;
    end else begin
      idleCnt_q <= idleCnt_q + 13'h0001;
    end
  end

  // internal oscillator rate or external clock divided by five
  always_ff @(posedge core_clk) begin
    if (srst) begin
      oscCnt_q   <= 8'h00;
      extCnt_q   <= 3'h0;
      sampleTick <= 1'b0;
    end else if (extActive) begin
      oscCnt_q   <= 8'h00;
      sampleTick <= 1'b0;
      if (pinRise) begin
        if (extCnt_q == 3'(EXT_CLK_DIV - 1)) begin //R16
          extCnt_q   <= 3'h0;
          sampleTick <= 1'b1;
        end else begin
          extCnt_q <= extCnt_q + 3'h1;
        end
      end
    end else begin
      extCnt_q <= 3'h0;
      if (oscCnt_q == 8'(OSC_DIV_CYC - 1)) begin //R12
        oscCnt_q   <= 8'h00;
        sampleTick <= 1'b1;
      end else begin
        oscCnt_q   <= oscCnt_q + 8'h01;
        sampleTick <= 1'b0;
      end
    end
  end

endmodule // sample_rate_gen

// ==== verilog/adc_continuous_serial_readout.sv ====
// Notes on behaviour
// [R01] system ties clock source select high for device clock; chip select may stay grounded
// [R02] while converting, serial clock and data stay high and busy is high
// [R03] at conversion end serial clock, busy and data fall: result ready, asleep
// [R04] after about 500 ns asleep, output starts on its own
// [R05] output spans first to 32nd rising serial clock edge, 32-bit word
// [R06] data changes on each falling serial clock edge
// [R07] internally made serial clock is driven on the clock pin
// [R08] receiver takes pending flag on edge 1, last bit on edge 32
// [R09] after edge 32 data goes high, clock stays high for the conversion
// [R10] oversample ratio spans 64 up to 32768
// [R11] filter notch sits at sample rate over oversample ratio
// [R12] grounded conversion clock pin selects on-chip 1.8 MHz oscillator
// [R13] one result per conversion, output rate is notch over 8
// [R14] internal notch halves with each doubling of the ratio
// [R15] ratio changes never alter the modulator sample rate
// [R16] external conversion clock gives sample rate of clock over 5
// [R17] serial data input held high selects ratio 32768
// [R18] device sleeps automatically after each conversion
// [R19] sleep lasts while chip select is high and nothing is shifted
// [R20] ratio 64 conversion takes about 0.285 ms
// [R21] data output is high impedance while chip select is high
// [R22] controller lets five rising edges pass before aborting output
// [R23] word sends pending flag first, then status, then result, msb first
//
// Local design decisions: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module adc_continuous_serial_readout (
  input  wire logic                        core_clk,
  input  wire logic                        srst,
  input  wire adc_serial_pkg::apbReq_t     apbReq,
  output adc_serial_pkg::apbRsp_t          apbRsp,
  input  wire logic                        serialClockSourceSelectN,
  input  wire logic                        chipSelectN,
  input  wire logic                        serialDataIn,
  input  wire logic                        conversionClockPin,
  input  wire logic [23:0]                 filterResult,
  output adc_serial_pkg::serialPins_t      serialPins
);
  import adc_serial_pkg::*;

  // oversample index clamped into the supported range
  function automatic logic [3:0] clampIdx(input logic [3:0] idx);
    clampIdx = (idx > 4'(RATIO_MAX_IDX)) ? 4'(RATIO_MAX_IDX) : idx;
  endfunction

  // samples per conversion: 8 * (64 << idx)
  function automatic logic [CONV_CNT_W-1:0] convLength(input logic [3:0] idx);
    convLength = CONV_CNT_W'(1) << (RATIO_BASE_LOG2 + CONV_PER_NOTCH_LOG2 + 32'(idx));
  endfunction

  convState_t                state_q;
  logic                      sck_q;
  logic                      sckOe_q;
  logic                      sdo_q;
  logic                      sdoOe_q;
  logic                      busy_q;
  logic [WORD_BITS-1:0]      shiftWord_q;
  logic [7:0]                halfCnt_q;
  logic [7:0]                sleepCnt_q;
  logic [5:0]                edgeCnt_q;
  logic [SDI_CODE_BITS-1:0]  sdiCode_q;
  logic [3:0]                activeIdx_q;
  logic [CONV_CNT_W-1:0]     convCnt_q;
  logic [3:0]                ctrlRatio_q;
  logic                      ctrlSdiSel_q;
  logic [WORD_BITS-1:0]      lastWord_q;
  logic [31:0]               convTotal_q;
  logic [31:0]               prdata_q;
  logic                      pready_q;
  logic                      pslverr_q;
  logic [2:0]                pinMeta_q;
  logic [2:0]                pinSync_q;
  logic                      sampleTick;
  logic                      extActive;
  logic                      convDone;
  logic                      halfDone;
  logic                      internalMode;
  logic                      csLow;
  logic                      sdiSync;
  logic [3:0]                selectedIdx;
  logic [3:0]                nextIdx;
  logic                      apbWrite;
  logic [WORD_BITS-1:0]      resultWord;

  // modulator sample rate source, independent of the ratio
  sample_rate_gen rateGen ( //R15
    .core_clk           (core_clk),
    .srst               (srst),
    .conversionClockPin (conversionClockPin),
    .sampleTick         (sampleTick),
    .extActive          (extActive)
  );

  // two-flop synchronisers for the select, chip select and data-in pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pinMeta_q <= 3'h0;
      pinSync_q <= 3'h0;
    end else begin
      pinMeta_q <= {serialClockSourceSelectN, chipSelectN, serialDataIn};
      pinSync_q <= pinMeta_q;
    end
  end

  assign internalMode = pinSync_q[2]; //R01
  assign csLow        = ~pinSync_q[1];
  assign sdiSync      = pinSync_q[0];

  // ratio for the next conversion: a high serial input forces the slowest
  assign selectedIdx = (ctrlSdiSel_q && (sdiCode_q == SDI_CODE_SLOWEST)) ? 4'(RATIO_MAX_IDX) //R17
                                                                          : clampIdx(ctrlRatio_q); //R10
  // an early abort keeps the previous ratio
  assign nextIdx     = (edgeCnt_q >= ABORT_MIN_EDGES) ? selectedIdx : activeIdx_q; //R22

  // pending flag first, then status, then result msb first
  assign resultWord  = {1'b0, 1'b0, extActive, filterResult, 1'b0, activeIdx_q}; //R23

  assign halfDone    = (halfCnt_q == 8'(SCK_HALF_CYC - 1));

  // conversion length: 8 * ratio modulator samples gives the notch/8 output rate
  assign convDone    = (state_q == CONVERT) && sampleTick &&
                       (convCnt_q == convLength(activeIdx_q) - CONV_CNT_W'(1)); //R11 R13 R14 R20

  // modulator sample counter for the running conversion
  always_ff @(posedge core_clk) begin
    if (srst) begin
      convCnt_q <= '0;
    end else if ((state_q != CONVERT) || convDone) begin
      convCnt_q <= '0;
    end else if (sampleTick) begin
      convCnt_q <= convCnt_q + CONV_CNT_W'(1);
    end
  end

  // conversion, sleep and shift sequencing with the serial pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q     <= CONVERT;
      sck_q       <= 1'b1;
      sdo_q       <= 1'b1;
      busy_q      <= 1'b1;
      shiftWord_q <= '0;
      halfCnt_q   <= 8'h00;
      sleepCnt_q  <= 8'h00;
      edgeCnt_q   <= 6'h00;
      sdiCode_q   <= '0;
      activeIdx_q <= CTRL_RATIO_RESET;
      lastWord_q  <= '0;
    end else begin
      unique case (state_q)
        CONVERT: begin
          sck_q  <= 1'b1; //R02 R09
          sdo_q  <= 1'b1; //R02
          busy_q <= 1'b1; //R02
          if (convDone) begin
            state_q     <= SLEEP; //R18
            shiftWord_q <= resultWord;
            lastWord_q  <= resultWord;
            sck_q       <= 1'b0; //R03
            sdo_q       <= 1'b0; //R03
            busy_q      <= 1'b0; //R03
            sleepCnt_q  <= 8'h00;
          end
        end
        SLEEP: begin
          if (sleepCnt_q != 8'(SLEEP_CYC - 1)) begin
            sleepCnt_q <= sleepCnt_q + 8'h01;
          end else if (csLow && internalMode) begin //R04 R19
            state_q   <= SHIFT;
            halfCnt_q <= 8'h00;
            edgeCnt_q <= 6'h00;
            sdiCode_q <= '0;
            sdo_q     <= shiftWord_q[WORD_BITS-1];
          end
        end
        SHIFT: begin
          if (!csLow) begin
            state_q     <= CONVERT;
            activeIdx_q <= nextIdx; //R22
            sck_q       <= 1'b1;
            sdo_q       <= 1'b1;
            busy_q      <= 1'b1;
          end else if (!halfDone) begin
            halfCnt_q <= halfCnt_q + 8'h01;
          end else begin
            halfCnt_q <= 8'h00;
            if (!sck_q) begin
              sck_q     <= 1'b1; //R07
              edgeCnt_q <= edgeCnt_q + 6'h01;
              if (edgeCnt_q < 6'(SDI_CODE_BITS)) begin
                sdiCode_q <= {sdiCode_q[SDI_CODE_BITS-2:0], sdiSync};
              end
            end else if (edgeCnt_q == 6'(WORD_BITS)) begin
              state_q     <= CONVERT; //R05 R09
              activeIdx_q <= nextIdx;
              sdo_q       <= 1'b1;
              busy_q      <= 1'b1;
            end else begin
              sck_q       <= 1'b0;
              shiftWord_q <= {shiftWord_q[WORD_BITS-2:0], 1'b0};
              sdo_q       <= shiftWord_q[WORD_BITS-2]; //R06
            end
          end
        end
      endcase
    end
  end

  // pin drivers: clock only in internal mode, data only while selected
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sckOe_q <= 1'b0;
      sdoOe_q <= 1'b0;
    end else begin
      sckOe_q <= internalMode; //R07
      sdoOe_q <= csLow; //R21
    end
  end

  assign serialPins = '{sck: sck_q, sckOe: sckOe_q, sdo: sdo_q, sdoOe: sdoOe_q, busy: busy_q};

  // conversions completed since reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      convTotal_q <= 32'h00000000;
    end else if (convDone) begin
      convTotal_q <= convTotal_q + 32'h00000001;
    end
  end

  assign apbWrite = apbReq.psel && apbReq.penable && pready_q && apbReq.pwrite;

  // control register writes
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ctrlRatio_q  <= CTRL_RATIO_RESET;
      ctrlSdiSel_q <= CTRL_SDI_RESET;
    end else if (apbWrite && (apbReq.paddr[7:0] == CTRL_OFFSET) && (apbReq.paddr[31:8] == 24'h000000)) begin
      ctrlRatio_q  <= apbReq.pwdata[CTRL_RATIO_LSB +: 4];
      ctrlSdiSel_q <= apbReq.pwdata[CTRL_SDI_SEL_BIT];
    end
  end

  // apb answer: read data prepared in the setup cycle, ready in the access cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= apbReq.psel && !apbReq.penable;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      if (apbReq.psel && !apbReq.penable) begin
        if (apbReq.paddr[31:8] != 24'h000000) begin
          pslverr_q <= 1'b1;
        end else begin
          unique case (apbReq.paddr[7:0])
            CTRL_OFFSET: begin
              prdata_q[CTRL_RATIO_LSB +: 4]  <= ctrlRatio_q;
              prdata_q[CTRL_SDI_SEL_BIT]     <= ctrlSdiSel_q;
            end
            STATUS_OFFSET: begin
              prdata_q[STAT_BUSY_BIT]        <= busy_q;
              prdata_q[STAT_EXT_BIT]         <= extActive;
              prdata_q[STAT_STATE_LSB +: 2]  <= state_q;
              prdata_q[STAT_IDX_LSB +: 4]    <= activeIdx_q;
              prdata_q[STAT_EDGES_LSB +: 6]  <= edgeCnt_q;
            end
            RESULT_OFFSET: begin
              prdata_q <= lastWord_q;
            end
            COUNT_OFFSET: begin
              prdata_q <= convTotal_q;
            end
            default: begin
              pslverr_q <= 1'b1;
            end
          endcase
        end
      end
    end
  end

  assign apbRsp = '{prdata: prdata_q, pready: pready_q, pslverr: pslverr_q};

endmodule // adc_continuous_serial_readout

// ==== verif/adc_readout_checker.sv ====
`timescale 1ns/1ps
module adc_readout_checker
  import adc_serial_pkg::*;
(
  input wire logic                    core_clk,
  input wire logic                    srst,
  input wire adc_serial_pkg::apbReq_t apbReq,
  input wire adc_serial_pkg::apbRsp_t apbRsp,
  input wire logic                    serialClockSourceSelectN,
  input wire logic                    chipSelectN,
  input wire logic                    serialDataIn,
  input wire logic                    conversionClockPin,
  input wire logic [23:0]             filterResult,
  input wire adc_serial_pkg::serialPins_t serialPins
);
  logic       sckPrev_q;
  logic [5:0] riseCnt_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // serial clock history for rise detection
  always_ff @(posedge core_clk) begin
    sckPrev_q <= serialPins.sck;
  end
  // rising serial clock edges seen in the current output cycle
  always_ff @(posedge core_clk) begin
    if (srst || serialPins.busy) begin
      riseCnt_q <= 6'h00;
    end else if (serialPins.sck && !sckPrev_q) begin
      riseCnt_q <= riseCnt_q + 6'h01;
    end
  end
  pready_timing_a: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
    else $error("pready missing after setup");
  pready_pulse_a: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("pready longer than one cycle");
  slverr_ready_a: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("pslverr without pready");
  conv_high_a: assert property (serialPins.busy |-> serialPins.sck && serialPins.sdo)
    else $error("clock or data low while converting");
  done_low_a: assert property ($fell(serialPins.busy) |-> !serialPins.sck && !serialPins.sdo)
    else $error("conversion end lines not low");
  sleep_min_a: assert property ($rose(serialPins.sck) && !serialPins.busy && riseCnt_q == 6'h00
    |-> !$past(serialPins.busy, 125)) else $error("sleep interval too short");
  sck_half_a: assert property ($fell(serialPins.sck) && !serialPins.busy && !$past(serialPins.busy)
    |-> $past(serialPins.sck, 25) && !$past(serialPins.sck, 26)) else $error("serial clock high time wrong");
  sdo_fall_a: assert property (!serialPins.busy && !$past(serialPins.busy) && $changed(serialPins.sdo)
    |-> $fell(serialPins.sck)) else $error("data changed off falling clock");
  last_edge_a: assert property ($rose(serialPins.sck) && riseCnt_q == 6'h1F && !serialPins.busy
    |-> ##25 serialPins.busy && serialPins.sdo) else $error("no new conversion after edge 32");
  sleep_hold_a: assert property (!serialPins.busy && riseCnt_q == 6'h00 && chipSelectN
    && $past(chipSelectN, 4) |=> !serialPins.busy && !serialPins.sck) else $error("left sleep while deselected");
  sdo_hiz_a: assert property (chipSelectN && $past(chipSelectN, 4) |-> !serialPins.sdoOe)
    else $error("data driven while deselected");
  abort_conv_a: assert property ($rose(chipSelectN) && !serialPins.busy && riseCnt_q != 6'h00
    |-> ##[1:6] serialPins.busy) else $error("abort did not start conversion");
endmodule // adc_readout_checker

// ==== verif/serial_receiver.sv ====
`timescale 1ns/1ps
module serial_receiver (
  input wire logic  core_clk,
  input wire logic  sck,
  input wire logic  sdo,
  input wire logic  busy,
  output logic [31:0] word,
  output int          bits
);
  logic        sckPrev;
  logic [31:0] shiftReg;
  initial begin
    sckPrev = 1'b1;
    shiftReg = '0;
    word = '0;
    bits = 0;
  end
  // listen only: take a bit at each rising clock, msb first, clear on a new conversion
  always @(posedge core_clk) begin
    sckPrev <= sck;
    if (busy) begin
      bits <= 0;
    end else if (sck && !sckPrev) begin
      shiftReg <= {shiftReg[30:0], sdo};
      bits <= bits + 1;
      if (bits == 31) begin
        word <= {shiftReg[30:0], sdo};
      end
    end
  end
endmodule // serial_receiver

// ==== verif/adc_continuous_serial_readout_test.sv ====
`timescale 1ns/1ps
module adc_continuous_serial_readout_test;
  import adc_serial_pkg::*;
  localparam logic [31:0] WORD0 = {3'b001, 24'h5A3C96, 5'h00};
  logic        core_clk, srst, selN, csN, sdi, ccp, extOn, err;
  logic [23:0] fr;
  logic [31:0] rxWord, rd;
  apbReq_t     req;
  apbRsp_t     rsp;
  serialPins_t pins;
  int          rxBits, error_cnt, comparisons, cyc;
  // core clock and external conversion clock
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (srst || !extOn) begin
      ccp <= 1'b0;
    end else begin
      ccp <= ~ccp;
    end
  end
  adc_continuous_serial_readout i_adc_continuous_serial_readout (.core_clk(core_clk), .srst(srst),
    .apbReq(req), .apbRsp(rsp), .serialClockSourceSelectN(selN), .chipSelectN(csN),
    .serialDataIn(sdi), .conversionClockPin(ccp), .filterResult(fr), .serialPins(pins));
  serial_receiver i_serial_receiver (.core_clk(core_clk), .sck(pins.sck), .sdo(pins.sdo),
    .busy(pins.busy), .word(rxWord), .bits(rxBits));
  task automatic summarize;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= d;
    @(posedge core_clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    if (k >= 50) begin
      chk("pready", 1, 0);
      summarize();
    end
  endtask
  task automatic waitBusy(input logic lvl);
    cyc = 0;
    while (pins.busy !== lvl && cyc < 60000) begin
      @(posedge core_clk);
      cyc++;
    end
    if (cyc >= 60000) begin
      chk("busyWait", 1, 0);
      summarize();
    end
  endtask
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    req = '0;
    selN = 1'b1;
    csN = 1'b0;
    sdi = 1'b0;
    extOn = 1'b0;
    fr = 24'h5A3C96;
    error_cnt = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    // register reset, unmapped access, ratio write
    apb(1'b0, {24'h0, CTRL_OFFSET}, 0); chk("ctrlReset", 32'h0000_0010, rd);
    apb(1'b0, 32'h0000_0010, 0); chk("unmappedErr", 1, 32'(err));
    chk("unmappedData", 0, rd);
    apb(1'b1, {24'h0, CTRL_OFFSET}, 0);
    apb(1'b0, {24'h0, CTRL_OFFSET}, 0); chk("ctrlWrite", 0, rd);
    // external conversion clock, ratio 64: 2560 pin edges per conversion
    extOn <= 1'b1;
    waitBusy(0);
    waitBusy(1);
    waitBusy(0); chk("convCycles", 1, {31'h0, cyc >= 5100 && cyc <= 5140});
    chk("sckOe", 1, 32'(pins.sckOe));
    waitBusy(1); chk("word", WORD0, rxWord);
    apb(1'b0, {24'h0, RESULT_OFFSET}, 0); chk("resultReg", WORD0, rd);
    apb(1'b0, {24'h0, STATUS_OFFSET}, 0); chk("extFlag", 1, 32'(rd[1]));
    // abort after six rising edges, then sleep while deselected
    waitBusy(0);
    repeat (420) @(posedge core_clk);
    csN <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk("abortBusy", 1, 32'(pins.busy));
    waitBusy(0);
    repeat (300) @(posedge core_clk);
    chk("sleepBusy", 0, 32'(pins.busy));
    chk("sleepSck", 0, 32'(pins.sck));
    chk("sdoHiZ", 0, 32'(pins.sdoOe));
    csN <= 1'b0;
    waitBusy(1); chk("wordAfterAbort", WORD0, rxWord);
    // serial input held high selects the slowest ratio
    apb(1'b1, {24'h0, CTRL_OFFSET}, 32'h0000_0010);
    sdi <= 1'b1;
    waitBusy(0);
    waitBusy(1);
    apb(1'b0, {24'h0, STATUS_OFFSET}, 0); chk("slowIdx", 9, 32'(rd[7:4]));
    // five conversions completed so far, one result each
    apb(1'b0, {24'h0, COUNT_OFFSET}, 0); chk("convCount", 5, rd);
    // grounded pin falls back to the on-chip oscillator
    extOn <= 1'b0;
    repeat (4300) @(posedge core_clk);
    apb(1'b0, {24'h0, STATUS_OFFSET}, 0); chk("intOsc", 0, 32'(rd[1]));
    summarize();
  end
endmodule // adc_continuous_serial_readout_test
bind adc_continuous_serial_readout adc_readout_checker i_adc_readout_checker (.core_clk(core_clk),
  .srst(srst), .apbReq(apbReq), .apbRsp(apbRsp), .serialClockSourceSelectN(serialClockSourceSelectN),
  .chipSelectN(chipSelectN), .serialDataIn(serialDataIn), .conversionClockPin(conversionClockPin),
  .filterResult(filterResult), .serialPins(serialPins));
